// ==== inc/acc_pkg.sv ====
package acc_pkg;
    localparam int NUM_CMP = 2;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CTRL0 = 12'h000;
    localparam logic [11:0] IDX_TRIM0 = 12'h001;
    localparam logic [11:0] IDX_CTRL1 = 12'h002;
    localparam logic [11:0] IDX_TRIM1 = 12'h003;
    localparam logic [11:0] IDX_FLAGS = 12'h004;
    localparam logic [11:0] IDX_SYS = 12'h005;
    // Control register fields
    localparam int CTRL_EN_BIT = 6;
    localparam int CTRL_INV_BIT = 5;
    localparam int CTRL_RES_BIT = 4;
    localparam int CTRL_SPD_LSB = 2;
    // Trim register fields
    localparam int TRIM_CAL_BIT = 6;
    localparam int TRIM_REF_BIT = 5;
    localparam int TRIM_VAL_LSB = 0;
    localparam int TRIM_W = 5;
    localparam int SPD_W = 2;
    // Sleep/idle control register field
    localparam int SYS_LOWPWR_BIT = 0;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] TRIM_RST = 8'h00;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
    typedef enum logic [1:0] {
        ACC_SPD_SLOWEST = 2'b00,
        ACC_SPD_SLOW = 2'b01,
        ACC_SPD_FAST = 2'b10,
        ACC_SPD_FASTEST = 2'b11
    } acc_speed_t;
endpackage

// ==== src/acc_channel.sv ====
`default_nettype none
// One comparator channel: sync, polarity, gating, change detect
module acc_channel
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic cmp_enable,
    input wire logic cmp_invert,
    input wire logic raw_async,
    output logic cmp_result_ff,
    output logic change_pulse_ff
);
    logic sync1_ff;
    logic sync2_ff;
    logic nxt_result;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= raw_async;
            sync2_ff <= sync1_ff;
        end
    end

    // Disabled comparator reads zero whatever the polarity
    assign nxt_result = cmp_enable ? (sync2_ff ^ cmp_invert) : 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_result_ff <= 1'b0;
        end else begin
            cmp_result_ff <= nxt_result;
        end
    end

    // Change taken from the register bit, not from any pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            change_pulse_ff <= 1'b0;
        end else begin
            change_pulse_ff <= nxt_result ^ cmp_result_ff;
        end
    end
endmodule
`default_nettype wire

// ==== src/acc_top.sv ====
// Operation
// - Disabled comparator powers down, result zero
// - Invert bit inverts the raw comparison result
// - Result reads one when plus exceeds minus
// - Two-bit speed field, 00 slowest, 11 fastest
// - Calibration mode bit; hysteresis off when calibrating
// - Reference select: minus at 0, plus 1
// - Five-bit read-write trim drives comparator offset
// - Result bit change sets interrupt flag
// - Flag during sleep with enable raises wakeup; the code wakes only when a result change sets a clear flag
// - Enabled comparator keeps running in low power
// - Shared port data reads zero while enabled
// - Enabling disconnects pull-highs on shared pins
// - Unimplemented bits read as zero
`default_nettype none
module acc_top
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CMP-1:0] cmp_raw_async,
    output logic [NUM_CMP-1:0] cmp_power_on,
    output logic [NUM_CMP-1:0] cmp_hyst_en,
    output logic [NUM_CMP-1:0] cmp_cal_ref_sel,
    output logic [NUM_CMP*SPD_W-1:0] cmp_speed_sel,
    output logic [NUM_CMP*TRIM_W-1:0] cmp_trim_value,
    output logic [NUM_CMP-1:0] cmp_pullup_off,
    output logic [NUM_CMP-1:0] cmp_port_read_mask,
    output logic [NUM_CMP-1:0] cmp_irq_flag,
    output logic wakeup_req
);
    logic [7:0] ctrl_ff [NUM_CMP];
    logic [7:0] trim_ff [NUM_CMP];
    logic [NUM_CMP-1:0] result;
    logic [NUM_CMP-1:0] change;
    logic [NUM_CMP-1:0] flag_ff;
    logic lowpwr_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [NUM_CMP-1:0] power_ff;
    logic [NUM_CMP-1:0] hyst_ff;
    logic [NUM_CMP-1:0] ref_ff;
    logic [NUM_CMP*SPD_W-1:0] speed_ff;
    logic [NUM_CMP*TRIM_W-1:0] tval_ff;
    logic [NUM_CMP-1:0] pullup_off_ff;
    logic [NUM_CMP-1:0] port_mask_ff;
    logic wake_ff;
    logic [11:0] idx;
    logic access;
    logic wr;
    logic addr_ok;
    logic [NUM_CMP-1:0] flag_wr;
    logic [NUM_CMP-1:0] flag_wdata;
    logic [31:0] nxt_prdata;
    logic [NUM_CMP-1:0] nxt_flag;

    assign idx = paddr[13:2];
    // Two-cycle access phase: pready rises in the second cycle of each access
    assign access = psel && penable && !pready_ff;
    assign wr = access && pwrite && addr_ok;
    assign addr_ok = (paddr[1:0] == 2'b00) && (idx <= IDX_SYS) && (paddr[31:14] == 18'h0_0000);

    genvar g;
    generate
        for (g = 0; g < NUM_CMP; g++) begin : g_cmp
            acc_channel u_ch (
                .pclk(pclk),
                .presetn(presetn),
                .cmp_enable(ctrl_ff[g][CTRL_EN_BIT]),
                .cmp_invert(ctrl_ff[g][CTRL_INV_BIT]),
                .raw_async(cmp_raw_async[g]),
                .cmp_result_ff(result[g]),
                .change_pulse_ff(change[g])
            );

            // Result bit is read-only; unimplemented bits stay zero
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ctrl_ff[g] <= CTRL_RST;
                end else if (wr && idx == IDX_CTRL0 + 12'(2 * g)) begin
                    ctrl_ff[g] <= {1'b0, pwdata[CTRL_EN_BIT], pwdata[CTRL_INV_BIT], 1'b0,
                                   pwdata[CTRL_SPD_LSB +: SPD_W], 2'b00};
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    trim_ff[g] <= TRIM_RST;
                end else if (wr && idx == IDX_TRIM0 + 12'(2 * g)) begin
                    trim_ff[g] <= {1'b0, pwdata[TRIM_CAL_BIT], pwdata[TRIM_REF_BIT],
                                   pwdata[TRIM_VAL_LSB +: TRIM_W]};
                end
            end

            // Analog-facing controls, registered
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    power_ff[g] <= 1'b0;
                    hyst_ff[g] <= 1'b0;
                    ref_ff[g] <= 1'b0;
                    speed_ff[g*SPD_W +: SPD_W] <= ACC_SPD_SLOWEST;
                    tval_ff[g*TRIM_W +: TRIM_W] <= '0;
                    pullup_off_ff[g] <= 1'b0;
                    port_mask_ff[g] <= 1'b0;
                end else begin
                    // Power stays up regardless of low-power mode
                    power_ff[g] <= ctrl_ff[g][CTRL_EN_BIT];
                    hyst_ff[g] <= !trim_ff[g][TRIM_CAL_BIT];
                    ref_ff[g] <= trim_ff[g][TRIM_REF_BIT];
                    speed_ff[g*SPD_W +: SPD_W] <= ctrl_ff[g][CTRL_SPD_LSB +: SPD_W];
                    tval_ff[g*TRIM_W +: TRIM_W] <= trim_ff[g][TRIM_VAL_LSB +: TRIM_W];
                    pullup_off_ff[g] <= ctrl_ff[g][CTRL_EN_BIT];
                    port_mask_ff[g] <= ctrl_ff[g][CTRL_EN_BIT];
                end
            end

            // Software may set or clear the flag; a change in the same cycle wins
            assign flag_wr[g] = wr && idx == IDX_FLAGS;
            assign flag_wdata[g] = pwdata[g];
            assign nxt_flag[g] = change[g] ? 1'b1 : (flag_wr[g] ? flag_wdata[g] : flag_ff[g]);
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_ff <= '0;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lowpwr_ff <= 1'b0;
        end else if (wr && idx == IDX_SYS) begin
            lowpwr_ff <= pwdata[SYS_LOWPWR_BIT];
        end
    end

    // Wake only on a fresh flag rise; a preset flag cannot rise again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= lowpwr_ff && |(change & ~flag_ff & power_ff);
        end
    end

    always_comb begin
        nxt_prdata = RDATA_ZERO;
        unique case (idx)
            IDX_CTRL0: nxt_prdata = {24'h00_0000, ctrl_ff[0] | {3'b000, result[0], 4'h0}};
            IDX_TRIM0: nxt_prdata = {24'h00_0000, trim_ff[0]};
            IDX_CTRL1: nxt_prdata = {24'h00_0000, ctrl_ff[1] | {3'b000, result[1], 4'h0}};
            IDX_TRIM1: nxt_prdata = {24'h00_0000, trim_ff[1]};
            IDX_FLAGS: nxt_prdata = {30'h0000_0000, flag_ff};
            IDX_SYS: nxt_prdata = {31'h0000_0000, lowpwr_ff};
            default: nxt_prdata = RDATA_ZERO;
        endcase
        if (!addr_ok) begin
            nxt_prdata = RDATA_ZERO;
        end
    end

    // Answer one cycle into the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= RDATA_ZERO;
        end else begin
            pready_ff <= access;
            pslverr_ff <= access && !addr_ok;
            if (access && !pwrite) begin
                prdata_ff <= nxt_prdata;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign cmp_power_on = power_ff;
    assign cmp_hyst_en = hyst_ff;
    assign cmp_cal_ref_sel = ref_ff;
    assign cmp_speed_sel = speed_ff;
    assign cmp_trim_value = tval_ff;
    assign cmp_pullup_off = pullup_off_ff;
    assign cmp_port_read_mask = port_mask_ff;
    assign cmp_irq_flag = flag_ff;
    assign wakeup_req = wake_ff;
endmodule
`default_nettype wire

// ==== bench/acc_chk.sv ====
`default_nettype none
module acc_chk
    import acc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_CMP-1:0] cmp_power_on,
    input wire logic [NUM_CMP-1:0] cmp_hyst_en,
    input wire logic [NUM_CMP*SPD_W-1:0] cmp_speed_sel,
    input wire logic [NUM_CMP*TRIM_W-1:0] cmp_trim_value,
    input wire logic [NUM_CMP-1:0] cmp_pullup_off,
    input wire logic [NUM_CMP-1:0] cmp_port_read_mask,
    input wire logic [NUM_CMP-1:0] cmp_irq_flag,
    input wire logic wakeup_req
);
    logic ok, wc, wt;
    assign ok = psel && penable && pready && !pslverr;
    assign wc = ok && pwrite && paddr == {18'h0_0000, IDX_CTRL0, 2'h0};
    assign wt = ok && pwrite && paddr == {18'h0_0000, IDX_TRIM0, 2'h0};
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_read_high_zero: assert property (ok && !pwrite |-> prdata[31:7] == 25'h000_0000) else $error("high bits");
    a_off_result_zero: assert property (ok && !pwrite && paddr[31:4] == 28'h000_0000 && paddr[2:0] == 3'h0
        && !prdata[6] |-> !prdata[4] && prdata[1:0] == 2'h0) else $error("off result");
    a_power_follows: assert property (wc |=> cmp_power_on[0] == $past(pwdata[6])) else $error("power");
    a_speed_follows: assert property (wc |=> cmp_speed_sel[1:0] == $past(pwdata[3:2])) else $error("speed");
    a_trim_follows: assert property (wt |=> cmp_trim_value[4:0] == $past(pwdata[4:0])) else $error("trim");
    a_hyst_follows: assert property (wt |=> cmp_hyst_en[0] != $past(pwdata[6])) else $error("hysteresis");
    a_pins_follow: assert property (cmp_pullup_off == cmp_power_on && cmp_port_read_mask == cmp_power_on)
        else $error("pin control");
    a_wake_cause: assert property (wakeup_req |-> (cmp_irq_flag & ~$past(cmp_irq_flag) & cmp_power_on) != 2'h0)
        else $error("wakeup");
    cover property (wakeup_req);
    cover property (wt);
    cover property (wc && pwdata[6]);
endmodule
bind acc_top acc_chk i_chk (.*);
`default_nettype wire

// ==== bench/testbench.sv ====
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import acc_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, wakeup_req, slv;
    logic [31:0] paddr = '0, pwdata = '0, prdata, rd, v;
    logic [1:0] raw = '0, cmp_power_on, cmp_hyst_en, cmp_cal_ref_sel, cmp_pullup_off, cmp_port_read_mask;
    logic [1:0] cmp_irq_flag;
    logic [3:0] cmp_speed_sel;
    logic [9:0] cmp_trim_value;
    int err_total = 0, checks_done = 0, seed = 51, wakes = 0, thr, up, dn, t, c;
    always #25 pclk = ~pclk;
    always @(posedge pclk) if (wakeup_req === 1'b1) wakes <= wakes + 1;
    acc_top i_dut (.*, .cmp_raw_async(raw));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string nm);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {18'h0_0000, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 9);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_total++;
            results();
        end
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 12'(i), '0);
            chk(rd, '0, "reset");
        end
        for (int i = 0; i < 8; i++) begin
            c = i % 2;
            v = $random(seed);
            v[6] = i[1] ^ i[2];
            v[3:2] = i[2:1];
            apb(1'b1, 12'(2 * c), v);
            raw <= 2'($random(seed));
            repeat (6) @(posedge pclk);
            apb(1'b0, 12'(2 * c), '0);
            chk(rd, {25'h000_0000, v[6:5], v[6] & (raw[c] ^ v[5]), v[3:2], 2'h0}, "ctl");
            chk({cmp_power_on[c], cmp_speed_sel[2 * c +: 2]}, {v[6], v[3:2]}, "out");
        end
        $display("test control done");
        apb(1'b1, IDX_CTRL0, 32'h0000_0040);
        thr = 1 + {$random(seed)} % 31;
        up = -1;
        dn = -1;
        // Analog stand-in: trim at or above the threshold flips the comparison
        for (int k = 0; k < 64; k++) begin
            t = k < 32 ? k : 63 - k;
            apb(1'b1, IDX_TRIM0, 32'h0000_0040 | 32'(t));
            raw[0] <= (t >= thr);
            repeat (6) @(posedge pclk);
            apb(1'b0, IDX_CTRL0, '0);
            if (k < 32 && rd[4] === 1'b1 && up < 0) up = t;
            if (k > 31 && rd[4] === 1'b0 && dn < 0) dn = t;
        end
        apb(1'b1, IDX_TRIM0, 32'h0000_0060 | 32'((up + dn) / 2));
        apb(1'b0, IDX_TRIM0, '0);
        chk(up, thr, "rise");
        chk(dn, thr - 1, "fall");
        chk(rd, 32'h0000_0060 | 32'(thr - 1), "trim");
        chk({cmp_hyst_en[0], cmp_cal_ref_sel[0], cmp_trim_value[4:0]}, {2'b01, 5'(thr - 1)}, "cal");
        $display("test calibration done");
        apb(1'b1, IDX_SYS, 32'h0000_0001);
        // Second pass presets the flag, which must suppress the wakeup
        for (int k = 0; k < 2; k++) begin
            apb(1'b1, IDX_FLAGS, '0);
            apb(1'b1, IDX_FLAGS, 32'(k));
            t = wakes;
            raw[0] <= !raw[0];
            repeat (8) @(posedge pclk);
            chk({cmp_irq_flag[0], 31'(wakes - t)}, {1'b1, 31'(1 - k)}, "irq");
        end
        $display("test interrupt done");
        apb(1'b0, 12'h006, '0);
        chk(rd, '0, "unmapped data");
        chk(slv, 1'b1, "unmapped error");
        $display("test unmapped done");
        results();
    end
endmodule
`default_nettype wire
